// >>> iqd_core.sv
// I/Q decimator with digital gain, manual/automatic gain control and signal strength.
// Assumes modulator samples arrive on clk; control port pins are asynchronous.
`timescale 1ns/1ps
module iqd_core (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // Modulator samples
    input  wire logic signed [iqd_pkg::MOD_W-1:0] mod_data,
    // Serial control port
    input  wire logic                        spi_sclk,
    input  wire logic                        spi_csn,
    input  wire logic                        spi_sdi,
    output logic                             spi_sdo,
    output logic                             spi_sdo_oe,
    // Decimated samples, one-cycle strobe
    output logic                             dec_strobe,
    output logic [iqd_pkg::OUT_W-1:0]        dec_i,
    output logic [iqd_pkg::OUT_W-1:0]        dec_q,
    output logic                             dec_accepted,
    // Buffered stream to the output formatter
    output logic                             out_valid,
    input  wire logic                        out_ready,
    output logic [iqd_pkg::OUT_W-1:0]        out_i,
    output logic [iqd_pkg::OUT_W-1:0]        out_q,
    output logic [iqd_pkg::SIGNAL_STRENGTH_FIELD_W-1:0]       out_signal_strength_field,
    // Analog gain controls
    output logic [7:0]                       gain_dac_code,
    output logic                             mixer_atten,
    output logic                             fast_acq
);
    import iqd_pkg::*;

    function automatic logic signed [MIX_W-1:0] mix(input logic signed [MOD_W-1:0] x,
                                                   input logic [2:0] ph);
        // Widen before the product so a full-scale sample cannot wrap
        mix = MIX_W'(x) * MIX_W'(COS_LUT[ph]);
    endfunction : mix

    function automatic logic [EST_W-1:0] mag(input logic [EST_W-1:0] v);
        mag = v[EST_W-1] ? EST_W'(-v) : v;
    endfunction : mag

    function automatic logic [SIGNAL_STRENGTH_FIELD_W-1:0] signal_strength_field_scale(input logic [EST_W:0] e);
        logic [EST_W+6:0] p;
        p = (EST_W+7)'(e) * (EST_W+7)'(SIGNAL_STRENGTH_FIELD_FULL);
        signal_strength_field_scale = p[EST_W+6 -: SIGNAL_STRENGTH_FIELD_W];
    endfunction : signal_strength_field_scale

    function automatic logic [OUT_W-1:0] pick(input logic [RES_W-1:0] r, input logic [1:0] sh);
        case (sh)
            2'h1:    pick = r[RES_W-2 -: OUT_W];
            2'h2:    pick = r[RES_W-3 -: OUT_W];
            default: pick = r[RES_W-1 -: OUT_W];
        endcase
    endfunction : pick

    // Registers
    logic [7:0]        gain_ref_ff;
    logic [7:0]        dec_cfg_ff;
    logic [GAIN_W-1:0] gain_set_ff;
    logic [7:0]        gain_hi_ff;
    logic [14:0]       agc_gain_ff;

    // Control port
    logic [2:0] sclk_sync_ff, csn_sync_ff, sdi_sync_ff;
    logic       sclk_filt_ff, csn_filt_ff;
    iqd_spi_e   spi_state_ff;
    logic [3:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] sdo_sh_ff;
    logic       rd_ff;
    logic [7:0] rd_data;

    wire sclk_ok   = (sclk_sync_ff[1] == sclk_sync_ff[2]);
    wire sclk_rise = sclk_ok && sclk_sync_ff[2] && !sclk_filt_ff;
    wire sclk_fall = sclk_ok && !sclk_sync_ff[2] && sclk_filt_ff;
    wire cs_active = !csn_filt_ff;
    wire [15:0] word = {shift_ff[14:0], sdi_sync_ff[2]};
    wire frame_end = cs_active && sclk_rise && (bit_cnt_ff == SPI_LAST_BIT);
    wire hdr_end   = cs_active && sclk_rise && (bit_cnt_ff == SPI_HDR_BIT);
    wire wr_evt    = frame_end && !word[15];
    wire [6:0] wr_addr = word[14:8];
    wire wr_ref    = wr_evt && (wr_addr == ADDR_GAIN_REF);
    wire wr_dec    = wr_evt && (wr_addr == ADDR_DEC_CFG);
    wire wr_ghi    = wr_evt && (wr_addr == ADDR_GAIN_HI);
    wire wr_glo    = wr_evt && (wr_addr == ADDR_GAIN_LO);

    // Effective settings
    wire [REF_W-1:0] ref_lvl = gain_ref_ff[REF_LSB +: REF_W];
    wire agc_on   = (ref_lvl != '0) && (ref_lvl <= REF_W'(5));
    wire dg_en    = gain_ref_ff[DGE_BIT];
    wire k_sel    = dec_cfg_ff[K_BIT];
    wire [M_W-1:0] m_raw = dec_cfg_ff[M_LSB +: M_W];
    wire [M_W-1:0] m_ratio = (m_raw == '0) ? M_W'(1) : m_raw;
    wire [2:0] r3 = k_sel ? STAGE3_RATIO_K1 : STAGE3_RATIO_K0;
    wire [14:0] att = agc_on ? agc_gain_ff : gain_set_ff[14:0];
    wire [15:0] eff_gain = {gain_set_ff[ATT_BIT], att};
    // Digital shift 2 means gain four, 0 means gain one
    wire [1:0] dg_shift = !dg_en ? 2'h0 : att[14] ? 2'h0 : att[13] ? 2'h1 : 2'h2;
    wire [7:0] dac_next = (!dg_en || att[14]) ? att[13:6] : 8'h00;

    always_comb begin
        if (spi_addr_is(ADDR_GAIN_HI)) begin
            rd_data = eff_gain[15:8];
        end else if (spi_addr_is(ADDR_GAIN_LO)) begin
            rd_data = eff_gain[7:0];
        end else if (spi_addr_is(ADDR_GAIN_REF)) begin
            rd_data = gain_ref_ff;
        end else if (spi_addr_is(ADDR_DEC_CFG)) begin
            rd_data = dec_cfg_ff;
        end else begin
            rd_data = 8'h00;
        end
    end

    function automatic logic spi_addr_is(input logic [6:0] a);
        spi_addr_is = (word[6:0] == a);
    endfunction : spi_addr_is

    always_ff @(posedge clk) begin
        sclk_sync_ff <= {sclk_sync_ff[1:0], spi_sclk};
        csn_sync_ff  <= {csn_sync_ff[1:0], spi_csn};
        sdi_sync_ff  <= {sdi_sync_ff[1:0], spi_sdi};
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sclk_filt_ff <= 1'b0;
            csn_filt_ff  <= 1'b1;
        end else begin
            if (sclk_ok) sclk_filt_ff <= sclk_sync_ff[2];
            if (csn_sync_ff[1] == csn_sync_ff[2]) csn_filt_ff <= csn_sync_ff[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || !cs_active) begin
            spi_state_ff <= SPI_IDLE;
            bit_cnt_ff   <= '0;
            shift_ff     <= '0;
            sdo_sh_ff    <= '0;
            rd_ff        <= 1'b0;
        end else begin
            case (spi_state_ff)
                SPI_IDLE: begin
                    spi_state_ff <= SPI_HDR;
                end
                SPI_HDR: begin
                    if (hdr_end) begin
                        spi_state_ff <= SPI_DATA;
                        rd_ff        <= word[7];
                        sdo_sh_ff    <= rd_data;
                    end
                end
                SPI_DATA: begin
                    if (frame_end) spi_state_ff <= SPI_HDR;
                    if (sclk_fall && bit_cnt_ff != SPI_HDR_BIT + 4'h1) begin
                        sdo_sh_ff <= {sdo_sh_ff[6:0], 1'b0};
                    end
                end
                default: spi_state_ff <= SPI_IDLE;
            endcase
            if (sclk_rise) begin
                shift_ff   <= word;
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    assign spi_sdo    = sdo_sh_ff[7];
    assign spi_sdo_oe = cs_active && rd_ff && (spi_state_ff == SPI_DATA);

    // Gain word is staged: high byte first, committed on the low byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            gain_ref_ff <= GAIN_REF_RST;
            dec_cfg_ff  <= DEC_CFG_RST;
            gain_hi_ff  <= GAIN_RST[15:8];
            gain_set_ff <= GAIN_RST;
        end else begin
            if (wr_ref) gain_ref_ff <= word[7:0];
            if (wr_dec) dec_cfg_ff <= word[7:0];
            if (wr_ghi) gain_hi_ff <= word[7:0];
            if (wr_glo) gain_set_ff <= {gain_hi_ff, word[7:0]};
        end
    end

    // Mixer and decimation datapath
    logic [2:0]        nco_ph_ff;
    logic [3:0]        cnt1_ff;
    logic [M_W-1:0]    cnt2_ff;
    logic [2:0]        cnt3_ff;
    iqd_acc_t          integ1_ff [2][ORDER];
    iqd_acc_t          dly1_ff   [2][ORDER];
    iqd_acc_t          integ2_ff [2][ORDER];
    iqd_acc_t          dly2_ff   [2][ORDER];
    iqd_acc_t          acc3_ff   [2];
    iqd_acc_t          mix_x     [2];
    iqd_acc_t          comb1     [2][ORDER+1];
    iqd_acc_t          comb2     [2][ORDER+1];
    logic              tick1_ff, tick2_ff;
    logic              tick3_ff;

    wire tick1 = (cnt1_ff == STAGE1_RATIO - 4'h1);
    wire tick2 = tick1_ff && (cnt2_ff >= m_ratio - M_W'(1));
    wire tick3 = tick2_ff && (cnt3_ff >= r3 - 3'h1);

    assign mix_x[0] = ACC_W'(mix(mod_data, nco_ph_ff));
    assign mix_x[1] = ACC_W'(-mix(mod_data, nco_ph_ff + 3'h6));

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            comb1[c][0] = integ1_ff[c][ORDER-1];
            comb2[c][0] = integ2_ff[c][ORDER-1];
            for (int k = 0; k < ORDER; k++) begin
                comb1[c][k+1] = comb1[c][k] - dly1_ff[c][k];
                comb2[c][k+1] = comb2[c][k] - dly2_ff[c][k];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            nco_ph_ff <= '0;
            cnt1_ff   <= '0;
            cnt2_ff   <= '0;
            cnt3_ff   <= '0;
            tick1_ff  <= 1'b0;
            tick2_ff  <= 1'b0;
            tick3_ff  <= 1'b0;
            integ1_ff <= '{default: '0};
            dly1_ff   <= '{default: '0};
            integ2_ff <= '{default: '0};
            dly2_ff   <= '{default: '0};
            acc3_ff   <= '{default: '0};
        end else begin
            nco_ph_ff <= nco_ph_ff + 3'h1;
            cnt1_ff   <= tick1 ? 4'h0 : cnt1_ff + 4'h1;
            tick1_ff  <= tick1;
            tick2_ff  <= tick2;
            tick3_ff  <= tick3;
            if (tick1_ff) cnt2_ff <= tick2 ? '0 : cnt2_ff + M_W'(1);
            if (tick2_ff) cnt3_ff <= tick3 ? '0 : cnt3_ff + 3'h1;
            for (int c = 0; c < 2; c++) begin
                integ1_ff[c][0] <= integ1_ff[c][0] + mix_x[c];
                for (int k = 1; k < ORDER; k++) begin
                    integ1_ff[c][k] <= integ1_ff[c][k] + integ1_ff[c][k-1];
                end
                if (tick1) begin
                    for (int k = 0; k < ORDER; k++) dly1_ff[c][k] <= comb1[c][k];
                    integ2_ff[c][0] <= integ2_ff[c][0] + comb1[c][ORDER];
                    for (int k = 1; k < ORDER; k++) begin
                        integ2_ff[c][k] <= integ2_ff[c][k] + integ2_ff[c][k-1];
                    end
                end
                if (tick2) begin
                    for (int k = 0; k < ORDER; k++) dly2_ff[c][k] <= comb2[c][k];
                    // Boxcar over r3 samples keeps the third stage linear phase
                    acc3_ff[c] <= ((cnt3_ff == '0) ? '0 : acc3_ff[c]) + comb2[c][ORDER];
                end
            end
        end
    end

    // Result is normalised to the largest second-stage ratio; small M gives small codes
    wire [RES_W-1:0] res_i = acc3_ff[0][RES_MSB -: RES_W];
    wire [RES_W-1:0] res_q = acc3_ff[1][RES_MSB -: RES_W];
    wire [OUT_W-1:0] dg_i  = pick(res_i, dg_shift);
    wire [OUT_W-1:0] dg_q  = pick(res_q, dg_shift);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dec_strobe <= 1'b0;
            dec_i      <= '0;
            dec_q      <= '0;
        end else begin
            dec_strobe <= tick3_ff;
            if (tick3_ff) begin
                dec_i <= dg_i;
                dec_q <= dg_q;
            end
        end
    end

    // Signal strength and gain loop
    logic [5:0]        signal_strength_field_cnt_ff;
    logic [EST_W:0]    peak_ff;
    logic [SIGNAL_STRENGTH_FIELD_W-1:0] signal_strength_field_ff;

    wire [EST_W:0] est1 = (EST_W+1)'(mag(comb1[0][ORDER][S1_MSB -: EST_W]))
                        + (EST_W+1)'(mag(comb1[1][ORDER][S1_MSB -: EST_W]));
    wire [EST_W:0] est2 = (EST_W+1)'(mag(dec_i[OUT_W-1 -: EST_W]))
                        + (EST_W+1)'(mag(dec_q[OUT_W-1 -: EST_W]));
    wire use1 = tick1 && (est1 > peak_ff);
    wire use2 = dec_strobe && dg_en && (est2 > peak_ff);
    wire signal_strength_field_tick = (signal_strength_field_cnt_ff == SIGNAL_STRENGTH_FIELD_PERIOD - 6'h01);
    wire [SIGNAL_STRENGTH_FIELD_W-1:0] target = AGC_TARGET[ref_lvl];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            signal_strength_field_cnt_ff <= '0;
            peak_ff     <= '0;
            signal_strength_field_ff     <= '0;
        end else begin
            signal_strength_field_cnt_ff <= signal_strength_field_tick ? 6'h00 : signal_strength_field_cnt_ff + 6'h01;
            if (signal_strength_field_tick) begin
                signal_strength_field_ff <= signal_strength_field_scale(peak_ff);
                peak_ff <= '0;
            end else if (use2) begin
                peak_ff <= est2;
            end else if (use1) begin
                peak_ff <= est1;
            end
        end
    end

    // Loop follows the manual word while off so that enabling it is bumpless
    always_ff @(posedge clk) begin
        if (!nrst) begin
            agc_gain_ff <= GAIN_RST[14:0];
        end else if (!agc_on) begin
            agc_gain_ff <= gain_set_ff[14:0];
        end else if (signal_strength_field_tick) begin
            if (signal_strength_field_ff > target && agc_gain_ff < AGC_MAX) begin
                agc_gain_ff <= agc_gain_ff + AGC_STEP;
            end else if (signal_strength_field_ff < target && agc_gain_ff >= AGC_STEP) begin
                agc_gain_ff <= agc_gain_ff - AGC_STEP;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            gain_dac_code <= '0;
            mixer_atten   <= 1'b0;
            fast_acq      <= 1'b0;
        end else begin
            gain_dac_code <= dac_next;
            mixer_atten   <= gain_set_ff[ATT_BIT];
            fast_acq      <= gain_ref_ff[FAST_BIT];
        end
    end

    // Output buffer
    logic              fifo_in_ready;
    logic [FIFO_W-1:0] fifo_out;

    assign dec_accepted = dec_strobe && fifo_in_ready;

    iqd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (dec_strobe),
        .in_ready  (fifo_in_ready),
        .in_data   ({dec_i, dec_q, signal_strength_field_ff}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out)
    );

    assign out_i    = fifo_out[FIFO_W-1 -: OUT_W];
    assign out_q    = fifo_out[SIGNAL_STRENGTH_FIELD_W +: OUT_W];
    assign out_signal_strength_field = fifo_out[SIGNAL_STRENGTH_FIELD_W-1:0];

endmodule : iqd_core

// >>> iqd_pkg.sv
// Shared constants for the I/Q decimator with gain control.
// Assumes one sampling clock; registers are written over the serial control port.
package iqd_pkg;

    // Datapath widths
    localparam int MOD_W  = 4;
    localparam int COEF_W = 9;
    localparam int MIX_W  = 13;
    localparam int ACC_W  = 52;
    localparam int RES_W  = 24;
    localparam int OUT_W  = 16;
    localparam int SIGNAL_STRENGTH_FIELD_W = 6;
    localparam int GAIN_W = 16;
    localparam int ORDER  = 4;
    localparam int FIFO_W = 38;
    localparam int FIFO_D = 32;

    typedef logic signed [ACC_W-1:0] iqd_acc_t;

    // Decimation ratios and counts
    localparam logic [3:0] STAGE1_RATIO    = 4'hC;
    localparam logic [2:0] STAGE3_RATIO_K0 = 3'h5;
    localparam logic [2:0] STAGE3_RATIO_K1 = 3'h4;
    localparam logic [5:0] SIGNAL_STRENGTH_FIELD_PERIOD   = 6'h3C;
    localparam logic [5:0] SIGNAL_STRENGTH_FIELD_FULL     = 6'h3C;

    // Bit positions inside the accumulators
    localparam int RES_MSB = 50;
    localparam int S1_MSB  = 28;
    localparam int EST_W   = 7;

    // Register addresses
    localparam logic [6:0] ADDR_GAIN_HI = 7'h03;
    localparam logic [6:0] ADDR_GAIN_LO = 7'h04;
    localparam logic [6:0] ADDR_GAIN_REF = 7'h06;
    localparam logic [6:0] ADDR_DEC_CFG = 7'h07;

    // Field positions
    localparam int REF_LSB  = 0;
    localparam int REF_W    = 3;
    localparam int FAST_BIT = 3;
    localparam int DGE_BIT  = 4;
    localparam int M_LSB    = 0;
    localparam int M_W      = 5;
    localparam int K_BIT    = 7;
    localparam int ATT_BIT  = 15;

    // Reset values
    localparam logic [7:0]        GAIN_REF_RST = 8'h00;
    localparam logic [7:0]        DEC_CFG_RST  = 8'h0E;
    localparam logic [GAIN_W-1:0] GAIN_RST     = 16'h0000;

    // Gain loop constants
    localparam logic [14:0] AGC_STEP = 15'h0040;
    localparam logic [14:0] AGC_MAX  = 15'h7FC0;
    localparam logic [SIGNAL_STRENGTH_FIELD_W-1:0] AGC_TARGET [6] = '{6'h3C, 6'h2A, 6'h1E, 6'h15, 6'h0F, 6'h0B};

    // Oscillator table at one eighth of the clock, Q8
    localparam logic signed [COEF_W-1:0] COS_LUT [8] = '{
        9'sh100, 9'sh0B5, 9'sh000, -9'sh0B5, -9'sh100, -9'sh0B5, 9'sh000, 9'sh0B5};

    // Control port framing
    localparam logic [3:0] SPI_LAST_BIT = 4'hF;
    localparam logic [3:0] SPI_HDR_BIT  = 4'h7;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_HDR  = 2'b01,
        SPI_DATA = 2'b10
    } iqd_spi_e;

endpackage : iqd_pkg

// >>> iqd_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module iqd_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    wire              push;
    wire              pop;

    assign in_ready  = (count_ff < (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : iqd_fifo

// >>> iqd_core_chk.sv
// Port assertions for the I/Q decimator core.
// Assumes one clock and a synchronous active-low reset; bound onto iqd_core.
`timescale 1ns/1ps
module iqd_core_chk (
    // Clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // Control port
    input wire logic              spi_csn,
    input wire logic              spi_sdo_oe,
    // Decimated samples
    input wire logic              dec_strobe,
    input wire logic [15:0]       dec_i,
    input wire logic [15:0]       dec_q,
    input wire logic              dec_accepted,
    // Buffered stream
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire logic [15:0]       out_i,
    input wire logic [5:0]        out_signal_strength_field
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Shortest composite ratio is 48, so eight quiet cycles always hold
    a_strobe_gap: assert property (dec_strobe |=> !dec_strobe [*8])
        else $error("decimated strobes too close");
    a_accept_strobe: assert property (dec_accepted |-> dec_strobe)
        else $error("accept without strobe");
    a_accept_room: assert property (dec_strobe && !out_valid |-> dec_accepted)
        else $error("sample dropped with empty buffer");
    a_dec_hold: assert property (!dec_strobe |-> $stable(dec_i) && $stable(dec_q))
        else $error("sample changed without strobe");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i))
        else $error("head word lost while stalled");
    a_valid_fall: assert property ($fell(out_valid) |-> $past(out_ready))
        else $error("valid fell without a pop");
    a_signal_strength_field_range: assert property (out_valid |-> out_signal_strength_field <= 6'h3C)
        else $error("strength above full scale");
    a_oe_frame: assert property (spi_sdo_oe |-> !$past(spi_csn, 7))
        else $error("readback driven outside a frame");
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !dec_strobe && !out_valid)
        else $error("output during reset");
    c_drop: cover property (dec_strobe && !dec_accepted);
    c_pop: cover property (out_valid && out_ready);
    c_read: cover property (spi_sdo_oe);
endmodule : iqd_core_chk

bind iqd_core iqd_core_chk i_chk (.clk(clk), .nrst(nrst), .spi_csn(spi_csn),
    .spi_sdo_oe(spi_sdo_oe), .dec_strobe(dec_strobe), .dec_i(dec_i), .dec_q(dec_q),
    .dec_accepted(dec_accepted), .out_valid(out_valid), .out_ready(out_ready),
    .out_i(out_i), .out_signal_strength_field(out_signal_strength_field));

// >>> iqd_bb.sv
// Baseband side model: drains the buffered I/Q stream.
// Assumes the bench drives stall; pops only every other cycle, so it is slow too.
`timescale 1ns/1ps
module iqd_bb (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Stream
    output logic     out_ready,
    // Bench control
    input wire logic stall
);
    logic tick_ff;
    always_ff @(posedge clk) begin
        tick_ff <= nrst ? ~tick_ff : 1'b0;
    end
    assign out_ready = !stall && tick_ff;
endmodule : iqd_bb

// >>> tb.sv
// Self-checking bench for the I/Q decimator core.
// Assumes 50 MHz clock; control frames are driven with 8-cycle sclk halves.
`timescale 1ns/1ps
module tb;
    import iqd_pkg::*;
    logic clk = 0, nrst = 0, sclk = 0, csn = 1, sdi = 0, stall = 0;
    logic signed [MOD_W-1:0] mod_data = '0;
    logic sdo, oe, strb, acc, ov, ordy, matt, fast;
    logic [15:0] di, dq, oi, oq;
    logic [5:0] signal_strength_field;
    logic [7:0] dac, r;
    logic [31:0] q[$];
    logic [6:0] ad [5] = '{7'h06, 7'h07, 7'h03, 7'h04, 7'h05};
    logic [7:0] ev [5] = '{8'h00, 8'h0E, 8'h00, 8'h00, 8'h00};
    int seed = 32'hfe28, fail_count = 0, compares = 0, cycles = 0;
    always #10 clk = ~clk;
    iqd_core i_dut (.clk(clk), .nrst(nrst), .mod_data(mod_data), .spi_sclk(sclk),
        .spi_csn(csn), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .dec_strobe(strb),
        .dec_i(di), .dec_q(dq), .dec_accepted(acc), .out_valid(ov), .out_ready(ordy),
        .out_i(oi), .out_q(oq), .out_signal_strength_field(signal_strength_field), .gain_dac_code(dac), .mixer_atten(matt),
        .fast_acq(fast));
    iqd_bb i_bb (.clk(clk), .nrst(nrst), .out_ready(ordy), .stall(stall));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // Mode 0 frame; readback bits are taken just before each of the last eight rises
    task automatic spi(input logic [15:0] w);
        csn = 0;
        cyc(8);
        for (int k = 15; k >= 0; k--) begin
            sdi = w[k];
            sclk = 0;
            cyc(8);
            if (k < 8) begin
                r[k] = sdo;
                chk(32'(oe), 32'(w[15]), "readback enable");
            end
            sclk = 1;
            cyc(8);
        end
        sclk = 0;
        cyc(8);
        csn = 1;
        cyc(8);
    endtask : spi
    task automatic wait_strb(output int t);
        int n;
        n = 0;
        while (strb !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        if (n == 2000) chk(0, 1, "no strobe");
        t = cycles;
        cyc(1);
    endtask : wait_strb
    function automatic int exp_ratio(input int m, input int k);
        return 12 * (m == 0 ? 1 : m) * (k ? 4 : 5);
    endfunction : exp_ratio
    function automatic logic [7:0] exp_dac(input logic [15:0] g, input logic dge);
        return (!dge || g[14]) ? g[13:6] : 8'h00;
    endfunction : exp_dac
    always @(posedge clk) begin
        #1 mod_data = MOD_W'($random(seed));
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("ERROR %0t timeout", $time);
            stop_test();
        end
    end
    // Sampled mid-cycle: strobe, valid and ready all launch on the rising edge
    always @(negedge clk) begin
        if (nrst && acc) q.push_back({di, dq});
        if (nrst && ov && ordy) chk(q.pop_front(), {oi, oq}, "stream word");
    end
    initial begin
        int t0, t1, m;
        logic [15:0] g;
        cyc(20);
        nrst = 1;
        cyc(6);
        for (int i = 0; i < 5; i++) begin
            spi({1'b1, ad[i], 8'h00});
            chk(32'(r), 32'(ev[i]), "reset read");
        end
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            g = (i == 0) ? 16'h8000 : (i == 1) ? 16'h3FC0 : 16'($random(seed));
            spi({1'b0, ADDR_GAIN_REF, 3'b000, i[0], i[1], 3'b000});
            spi({1'b0, ADDR_GAIN_HI, g[15:8]});
            spi({1'b0, ADDR_GAIN_LO, g[7:0]});
            chk(32'(matt), 32'(g[15]), "mixer attenuation");
            chk(32'(dac), 32'(exp_dac(g, i[0])), "dac code");
            chk(32'(fast), 32'(i[1]), "fast acquisition");
            spi({1'b1, ADDR_GAIN_HI, 8'h00});
            chk(32'(r), 32'(g[15:8]), "gain high");
        end
        // Loop steps are whole multiples of the step size, so the low bits stay manual
        spi({1'b0, ADDR_GAIN_REF, 8'h01});
        cyc(600);
        spi({1'b1, ADDR_GAIN_LO, 8'h00});
        chk(32'(r[5:0]), 32'(g[5:0]), "loop step grain");
        spi({1'b0, ADDR_GAIN_REF, 8'h06});
        spi({1'b1, ADDR_GAIN_LO, 8'h00});
        chk(32'(r), 32'(g[7:0]), "reserved reference");
        spi({1'b0, ADDR_GAIN_REF, 8'h00});
        $display("test gain done");
        for (int i = 0; i < 3; i++) begin
            m = (i == 2) ? 0 : 1 + (($random(seed) & 32'h7FFFFFFF) % 4);
            spi({1'b0, ADDR_DEC_CFG, i[0], 2'b00, 5'(m)});
            for (int j = 0; j < 3; j++) wait_strb(t0);
            wait_strb(t1);
            chk(32'(t1 - t0), 32'(exp_ratio(m, i % 2)), "strobe period");
        end
        $display("test ratio done");
        spi({1'b0, ADDR_DEC_CFG, 8'h81});
        stall = 1;
        for (int n = 0; n < 3000 && !(strb && !acc); n++) cyc(1);
        chk(32'(q.size()), 32'(FIFO_D), "buffer fill");
        stall = 0;
        for (int n = 0; n < 3000 && q.size() != 0; n++) cyc(1);
        cyc(3);
        chk(32'(ov), 32'(q.size() != 0), "buffer drained");
        $display("test buffer done");
        stop_test();
    end
endmodule : tb
